// *** rtl/tal_pkg.sv ***
// Constants, register map and mode encoding for the tributary alarm and loopback block
package tal_pkg;
   // ==========================================================
   // Sizes
   localparam int NUM_PORTS    = 28;
   localparam int NUM_FRAMERS  = 7;
   localparam int E3_FRAMERS   = 4;
   localparam int ADDR_W       = 8;
   localparam int DATA_W       = 16;
   localparam int LO_W         = 16;
   localparam int HI_W         = 12;
   localparam int CNT_W        = 10;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] STAT_LOF_AIS_ADDR = 8'h34;
   localparam logic [7:0] STAT_RAI_ADDR     = 8'h36;
   localparam logic [7:0] RX_CTRL_LO_ADDR   = 8'h40;
   localparam logic [7:0] RX_CTRL_HI_ADDR   = 8'h42;
   localparam logic [7:0] TX_CTRL_LO_ADDR   = 8'h44;
   localparam logic [7:0] TX_CTRL_HI_ADDR   = 8'h46;
   localparam logic [7:0] CFG_ADDR          = 8'h48;
   localparam logic [7:0] LINE_LO_ADDR      = 8'h50;
   localparam logic [7:0] LINE_HI_ADDR      = 8'h52;
   localparam logic [7:0] DIAG_LO_ADDR      = 8'h54;
   localparam logic [7:0] DIAG_HI_ADDR      = 8'h56;

   // ==========================================================
   // Configuration fields and reset values
   localparam int CFG_MODE_LSB   = 0;
   localparam int CFG_MUXDIS_BIT = 2;
   localparam int CFG_TIMED_BIT  = 3;
   localparam int CFG_W          = 4;
   localparam int STAT_AIS_LSB   = 8;
   localparam logic [NUM_PORTS-1:0] CTRL_RESET = 28'h0000000;

   typedef enum logic [1:0] {
      MODE_T1    = 2'b00,
      MODE_E3    = 2'b01,
      MODE_G747  = 2'b10,
      MODE_RSVD  = 2'b11
   } tal_mode_type;

   // Active port masks, bit n-1 is port n
   localparam logic [NUM_PORTS-1:0] ACT_ALL     = 28'hfffffff;
   localparam logic [NUM_PORTS-1:0] ACT_E3      = 28'h000ffff;
   localparam logic [NUM_PORTS-1:0] ACT_G747_RX = 28'h7777777;
   localparam logic [NUM_PORTS-1:0] ACT_G747_TX = 28'h0177777;

   // ==========================================================
   // Second-order framer figures
   localparam logic [CNT_W-1:0] E2_FRAME_LEN   = 10'h350;
   localparam logic [CNT_W-1:0] G747_FRAME_LEN = 10'h348;
   localparam logic [CNT_W-1:0] FAS_END_POS    = 10'h009;
   localparam logic [CNT_W-1:0] E2_RAI_POS     = 10'h00a;
   localparam logic [CNT_W-1:0] G747_RAI_POS   = 10'h0d2;
   localparam logic [9:0]       E2_FAS_WORD    = 10'h3d0;
   localparam logic [9:0]       G747_FAS_WORD  = 10'h3a0;
   localparam logic [CNT_W-1:0] AIS_MAX_ZEROS  = 10'h004;
   localparam logic [2:0]       LOF_BAD_CNT    = 3'h4;
   localparam logic [1:0]       LOF_GOOD_CNT   = 2'h3;
   localparam logic [2:0]       RAI_CNT        = 3'h4;
endpackage : tal_pkg

// *** rtl/tal_framer.sv ***
// Second-order frame monitor: alignment, all-ones and remote alarm detection
`timescale 1ns/10ps
module tal_framer (
   // Clock and reset
   input  wire logic clk,
   input  wire logic arst_n,
   // Bit stream, one enable per bit
   input  wire logic bit_en,
   input  wire logic bit_val,
   input  wire logic enable,
   input  wire logic g747,
   // Alarm levels
   output logic      ais,
   output logic      frame_loss,
   output logic      remote_alarm
);
   logic [tal_pkg::CNT_W-1:0] pos;
   logic [tal_pkg::CNT_W-1:0] zeros;
   logic [8:0]                shift;
   logic                      low_prev;
   logic [2:0]                bad_cnt;
   logic [1:0]                good_cnt;
   logic [2:0]                rai_cnt;

   wire [tal_pkg::CNT_W-1:0] frame_len = g747 ? tal_pkg::G747_FRAME_LEN : tal_pkg::E2_FRAME_LEN;
   wire [tal_pkg::CNT_W-1:0] rai_pos   = g747 ? tal_pkg::G747_RAI_POS : tal_pkg::E2_RAI_POS;
   wire [9:0]  fas_word    = {shift, bit_val};
   wire        fas_ok      = fas_word == (g747 ? tal_pkg::G747_FAS_WORD : tal_pkg::E2_FAS_WORD);
   wire        at_last     = pos == frame_len - 10'h001;
   wire        at_fas      = pos == tal_pkg::FAS_END_POS;
   wire        at_rai      = pos == rai_pos;
   wire [tal_pkg::CNT_W-1:0] frame_zeros = zeros + {9'h000, ~bit_val};
   wire        frame_low   = frame_zeros <= tal_pkg::AIS_MAX_ZEROS;
   // Hunting slips one bit per bad word until alignment is found
   wire        slip        = frame_loss && at_fas && !fas_ok;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pos   <= '0;
         zeros <= '0;
         shift <= '0;
      end else if (!enable) begin
         pos   <= '0;
         zeros <= '0;
      end else if (bit_en) begin
         shift <= fas_word[8:0];
         pos   <= slip ? pos : (at_last ? '0 : pos + 10'h001);
         zeros <= at_last ? '0 : frame_zeros;
      end
   end

   // ==========================================================
   // Frame alignment
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         frame_loss      <= 1'b0;
         bad_cnt  <= '0;
         good_cnt <= '0;
      end else if (!enable) begin
         frame_loss      <= 1'b0;
         bad_cnt  <= '0;
         good_cnt <= '0;
      end else if (bit_en && at_fas) begin
         if (fas_ok) begin
            bad_cnt  <= '0;
            good_cnt <= (good_cnt == tal_pkg::LOF_GOOD_CNT) ? good_cnt : good_cnt + 2'h1;
            if (good_cnt + 2'h1 == tal_pkg::LOF_GOOD_CNT) frame_loss <= 1'b0;
         end else begin
            good_cnt <= '0;
            bad_cnt  <= (bad_cnt == tal_pkg::LOF_BAD_CNT) ? bad_cnt : bad_cnt + 3'h1;
            if (bad_cnt + 3'h1 == tal_pkg::LOF_BAD_CNT) frame_loss <= 1'b1;
         end
      end
   end

   // ==========================================================
   // All-ones and remote alarm
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ais      <= 1'b0;
         low_prev <= 1'b0;
         remote_alarm      <= 1'b0;
         rai_cnt  <= '0;
      end else if (!enable) begin
         ais      <= 1'b0;
         low_prev <= 1'b0;
         remote_alarm      <= 1'b0;
         rai_cnt  <= '0;
      end else if (bit_en) begin
         if (at_last) begin
            low_prev <= frame_low;
            if (frame_low && low_prev) ais <= 1'b1;
            if (!frame_low && !low_prev) ais <= 1'b0;
         end
         if (at_rai) begin
            if (bit_val != remote_alarm) begin
               rai_cnt <= (rai_cnt + 3'h1 == tal_pkg::RAI_CNT) ? '0 : rai_cnt + 3'h1;
               if (rai_cnt + 3'h1 == tal_pkg::RAI_CNT) remote_alarm <= bit_val;
            end else begin
               rai_cnt <= '0;
            end
         end
      end
   end

   sequence low_frame_s;
      enable && bit_en && at_last && frame_low;
   endsequence
   ais_set_a : assert property (@(posedge clk) disable iff (!arst_n)
      low_frame_s and low_prev |=> ais) else $error("AIS not declared after two low frames");
   lof_set_a : assert property (@(posedge clk) disable iff (!arst_n)
      enable && bit_en && at_fas && !fas_ok && bad_cnt == 3'h3 |=> frame_loss) else $error("FRAME_LOSS not declared");
   rai_set_a : assert property (@(posedge clk) disable iff (!arst_n)
      enable && bit_en && at_rai && bit_val && !remote_alarm && rai_cnt == 3'h3 |=> remote_alarm) else $error("REMOTE_ALARM not set");
endmodule : tal_framer

// *** rtl/tal_top.sv ***
// Tributary all-ones insertion, loopbacks and second-order alarm monitors
//
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
module tal_top (
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          arst_n,
   // Register port
   input  wire logic [tal_pkg::ADDR_W-1:0]    addr,
   input  wire logic [tal_pkg::DATA_W-1:0]    wdata,
   input  wire logic                          wr_en,
   input  wire logic                          rd_en,
   output logic      [tal_pkg::DATA_W-1:0]    rdata,
   // Demultiplexed receive side, same clock domain
   input  wire logic [tal_pkg::NUM_PORTS-1:0] mux_rx_clock,
   input  wire logic [tal_pkg::NUM_PORTS-1:0] mux_rx_data,
   // Tributary receive outputs
   output logic      [tal_pkg::NUM_PORTS-1:0] trib_rx_clock_out,
   output logic      [tal_pkg::NUM_PORTS-1:0] trib_rx_data_out,
   // Tributary transmit pins
   input  wire logic [tal_pkg::NUM_PORTS-1:0] trib_tx_clock_in,
   input  wire logic [tal_pkg::NUM_PORTS-1:0] trib_tx_data_in,
   // Toward the multiplexer
   output logic      [tal_pkg::NUM_PORTS-1:0] mux_tx_data,
   output logic      [tal_pkg::NUM_PORTS-1:0] mux_tx_strobe,
   // Second-order streams for the monitors
   input  wire logic [tal_pkg::NUM_FRAMERS-1:0] so_clock_in,
   input  wire logic [tal_pkg::NUM_FRAMERS-1:0] so_data_in
);
   localparam int NP = tal_pkg::NUM_PORTS;
   localparam int NF = tal_pkg::NUM_FRAMERS;
   localparam int LW = tal_pkg::LO_W;
   localparam int HW = tal_pkg::HI_W;

   // ==========================================================
   // Control registers
   logic [NP-1:0]              rx_pass;
   logic [NP-1:0]              tx_pass;
   logic [NP-1:0]              line_loop_enable;
   logic [NP-1:0]              diag_loop_enable;
   logic [tal_pkg::CFG_W-1:0]  cfg;

   wire wr_rx_lo   = wr_en && addr == tal_pkg::RX_CTRL_LO_ADDR;
   wire wr_rx_hi   = wr_en && addr == tal_pkg::RX_CTRL_HI_ADDR;
   wire wr_tx_lo   = wr_en && addr == tal_pkg::TX_CTRL_LO_ADDR;
   wire wr_tx_hi   = wr_en && addr == tal_pkg::TX_CTRL_HI_ADDR;
   wire wr_line_lo = wr_en && addr == tal_pkg::LINE_LO_ADDR;
   wire wr_line_hi = wr_en && addr == tal_pkg::LINE_HI_ADDR;
   wire wr_diag_lo = wr_en && addr == tal_pkg::DIAG_LO_ADDR;
   wire wr_diag_hi = wr_en && addr == tal_pkg::DIAG_HI_ADDR;
   wire wr_cfg     = wr_en && addr == tal_pkg::CFG_ADDR;

   // Zero pass bits mean all-ones on every path after reset
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_pass <= tal_pkg::CTRL_RESET;
         tx_pass <= tal_pkg::CTRL_RESET;
      end else begin
         if (wr_rx_lo) rx_pass[LW-1:0]     <= wdata;
         if (wr_rx_hi) rx_pass[NP-1:LW]    <= wdata[HW-1:0];
         if (wr_tx_lo) tx_pass[LW-1:0]     <= wdata;
         if (wr_tx_hi) tx_pass[NP-1:LW]    <= wdata[HW-1:0];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         line_loop_enable <= tal_pkg::CTRL_RESET;
         diag_loop_enable <= tal_pkg::CTRL_RESET;
         cfg              <= '0;
      end else begin
         if (wr_line_lo) line_loop_enable[LW-1:0]  <= wdata;
         if (wr_line_hi) line_loop_enable[NP-1:LW] <= wdata[HW-1:0];
         if (wr_diag_lo) diag_loop_enable[LW-1:0]  <= wdata;
         if (wr_diag_hi) diag_loop_enable[NP-1:LW] <= wdata[HW-1:0];
         if (wr_cfg)     cfg                       <= wdata[tal_pkg::CFG_W-1:0];
      end
   end

   wire [1:0] mode_bits          = cfg[tal_pkg::CFG_MODE_LSB +: 2];
   wire       mux_disable_select = cfg[tal_pkg::CFG_MUXDIS_BIT];
   wire       port_loop_timed    = cfg[tal_pkg::CFG_TIMED_BIT];
   wire       mode_e3            = mode_bits == tal_pkg::MODE_E3;
   wire       mode_g747          = mode_bits == tal_pkg::MODE_G747;

   // ==========================================================
   // Active ports and effective controls
   wire [NP-1:0] act_rx = mode_e3 ? tal_pkg::ACT_E3 :
                          mode_g747 ? tal_pkg::ACT_G747_RX : tal_pkg::ACT_ALL;
   wire [NP-1:0] act_tx = mode_e3 ? tal_pkg::ACT_E3 :
                          mode_g747 ? tal_pkg::ACT_G747_TX : tal_pkg::ACT_ALL;
   // Inactive ports idle at all-ones whatever their bits say
   wire [NP-1:0] rx_ones  = ~act_rx | ({NP{~mux_disable_select}} & ~rx_pass);
   wire [NP-1:0] tx_ones  = ~act_tx | ({NP{~mux_disable_select}} & ~tx_pass);
   wire [NP-1:0] line_eff = line_loop_enable & act_tx;
   wire [NP-1:0] diag_eff = diag_loop_enable & act_rx;

   // ==========================================================
   // Pin synchronisers
   logic [NP-1:0] tx_clk_m;
   logic [NP-1:0] tx_clk_s;
   logic [NP-1:0] tx_dat_m;
   logic [NP-1:0] tx_dat_s;
   logic [NF-1:0] so_clk_m;
   logic [NF-1:0] so_clk_s;
   logic [NF-1:0] so_clk_d;
   logic [NF-1:0] so_dat_m;
   logic [NF-1:0] so_dat_s;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_clk_m <= '0;
         tx_clk_s <= '0;
         tx_dat_m <= '0;
         tx_dat_s <= '0;
      end else begin
         tx_clk_m <= trib_tx_clock_in;
         tx_clk_s <= tx_clk_m;
         tx_dat_m <= trib_tx_data_in;
         tx_dat_s <= tx_dat_m;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         so_clk_m <= '0;
         so_clk_s <= '0;
         so_clk_d <= '0;
         so_dat_m <= '0;
         so_dat_s <= '0;
      end else begin
         so_clk_m <= so_clock_in;
         so_clk_s <= so_clk_m;
         so_clk_d <= so_clk_s;
         so_dat_m <= so_data_in;
         so_dat_s <= so_dat_m;
      end
   end

   // ==========================================================
   // Receive output path
   logic [NP-1:0] rx_clk_prev;
   // Loop-timed keeps the demultiplexed clock even in diagnostic loopback
   wire [NP-1:0] rx_clk_sel = (diag_eff & {NP{~port_loop_timed}} & tx_clk_s) |
                              (~(diag_eff & {NP{~port_loop_timed}}) & mux_rx_clock);
   wire [NP-1:0] rx_src     = (diag_eff & tx_dat_s) | (~diag_eff & mux_rx_data);
   wire [NP-1:0] rx_edge    = rx_clk_sel & ~rx_clk_prev;
   wire [NP-1:0] next_rx    = rx_ones | rx_src;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_clk_prev       <= '0;
         trib_rx_clock_out <= '0;
         trib_rx_data_out  <= '1;
      end else begin
         rx_clk_prev       <= rx_clk_sel;
         trib_rx_clock_out <= rx_clk_sel;
         trib_rx_data_out  <= (rx_edge & next_rx) | (~rx_edge & trib_rx_data_out);
      end
   end

   // ==========================================================
   // Transmit path toward the multiplexer
   logic [NP-1:0] tx_clk_prev;
   wire [NP-1:0] tx_clk_sel = (line_eff & mux_rx_clock) | (~line_eff & tx_clk_s);
   wire [NP-1:0] tx_src     = (line_eff & mux_rx_data) | (~line_eff & tx_dat_s);
   wire [NP-1:0] tx_edge    = tx_clk_sel & ~tx_clk_prev;
   wire [NP-1:0] next_tx    = tx_ones | tx_src;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_clk_prev   <= '0;
         mux_tx_data   <= '1;
         mux_tx_strobe <= '0;
      end else begin
         tx_clk_prev   <= tx_clk_sel;
         mux_tx_data   <= (tx_edge & next_tx) | (~tx_edge & mux_tx_data);
         mux_tx_strobe <= tx_edge;
      end
   end

   // ==========================================================
   // Second-order monitors and latched status
   logic [NF-1:0] ais_live;
   logic [NF-1:0] lof_live;
   logic [NF-1:0] rai_live;
   logic [NF-1:0] ais_latch;
   logic [NF-1:0] lof_latch;
   logic [NF-1:0] rai_latch;
   wire  [NF-1:0] so_edge = so_clk_s & ~so_clk_d;

   genvar g;
   generate
      for (g = 0; g < NF; g++) begin : g_framer
         tal_framer u_framer (
            .clk     (clk),
            .arst_n  (arst_n),
            .bit_en  (so_edge[g]),
            .bit_val (so_dat_s[g]),
            .enable  (mode_g747 || (mode_e3 && g < tal_pkg::E3_FRAMERS)),
            .g747    (mode_g747),
            .ais     (ais_live[g]),
            .frame_loss     (lof_live[g]),
            .remote_alarm     (rai_live[g])
         );
      end
   endgenerate

   wire rd_stat1 = rd_en && addr == tal_pkg::STAT_LOF_AIS_ADDR;
   wire rd_stat2 = rd_en && addr == tal_pkg::STAT_RAI_ADDR;

   // A live alarm wins over the read clear
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ais_latch <= '0;
         lof_latch <= '0;
         rai_latch <= '0;
      end else begin
         ais_latch <= ais_live | (ais_latch & {NF{~rd_stat1}});
         lof_latch <= lof_live | (lof_latch & {NF{~rd_stat1}});
         rai_latch <= rai_live | (rai_latch & {NF{~rd_stat2}});
      end
   end

   // ==========================================================
   // Read-back
   wire [LW-1:0] rd_stat1_val = {1'b0, ais_latch, 1'b0, lof_latch};
   wire [LW-1:0] rd_stat2_val = {{(LW-NF){1'b0}}, rai_latch};
   wire [LW-1:0] hi_pad       = '0;
   wire [LW-1:0] rd_val =
      rd_stat1                            ? rd_stat1_val :
      rd_stat2                            ? rd_stat2_val :
      addr == tal_pkg::RX_CTRL_LO_ADDR    ? rx_pass[LW-1:0] :
      addr == tal_pkg::RX_CTRL_HI_ADDR    ? {hi_pad[LW-1:HW], rx_pass[NP-1:LW]} :
      addr == tal_pkg::TX_CTRL_LO_ADDR    ? tx_pass[LW-1:0] :
      addr == tal_pkg::TX_CTRL_HI_ADDR    ? {hi_pad[LW-1:HW], tx_pass[NP-1:LW]} :
      addr == tal_pkg::LINE_LO_ADDR       ? line_loop_enable[LW-1:0] :
      addr == tal_pkg::LINE_HI_ADDR       ? {hi_pad[LW-1:HW], line_loop_enable[NP-1:LW]} :
      addr == tal_pkg::DIAG_LO_ADDR       ? diag_loop_enable[LW-1:0] :
      addr == tal_pkg::DIAG_HI_ADDR       ? {hi_pad[LW-1:HW], diag_loop_enable[NP-1:LW]} :
      addr == tal_pkg::CFG_ADDR           ? {hi_pad[LW-1:tal_pkg::CFG_W], cfg} : '0;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= '0;
      end else begin
         rdata <= rd_en ? rd_val : '0;
      end
   end

   // ==========================================================
   // Checks
   rx_ones_a : assert property (@(posedge clk) disable iff (!arst_n)
      rx_edge[0] && rx_ones[0] |=> trib_rx_data_out[0] [*2]) else $error("Receive all-ones missing");
   tx_ones_a : assert property (@(posedge clk) disable iff (!arst_n)
      tx_edge[1] && tx_ones[1] |=> mux_tx_data[1]) else $error("Transmit all-ones missing");
   line_loop_a : assert property (@(posedge clk) disable iff (!arst_n)
      tx_edge[2] && line_eff[2] && !tx_ones[2] |=> mux_tx_data[2] == $past(mux_rx_data[2]))
      else $error("Line loopback data wrong");
   diag_loop_a : assert property (@(posedge clk) disable iff (!arst_n)
      rx_edge[3] && diag_eff[3] && !rx_ones[3] |=> trib_rx_data_out[3] == $past(tx_dat_s[3]))
      else $error("Diagnostic loopback data wrong");
   timed_clock_a : assert property (@(posedge clk) disable iff (!arst_n)
      port_loop_timed && diag_eff[0] |=> trib_rx_clock_out[0] == $past(mux_rx_clock[0]))
      else $error("Clock looped in loop-timed mode");
   mux_dis_a : assert property (@(posedge clk) disable iff (!arst_n)
      mux_disable_select |-> (rx_ones & act_rx) == '0 && (tx_ones & act_tx) == '0)
      else $error("Alarm bits active with multiplexer disabled");
   g747_ignore_a : assert property (@(posedge clk) disable iff (!arst_n)
      mode_g747 |-> rx_ones[3] && tx_ones[21] && !diag_eff[7]) else $error("Inactive port not ignored");
   read_clear_a : assert property (@(posedge clk) disable iff (!arst_n)
      rd_stat1 && !lof_live[0] ##1 !lof_live[0] |-> !lof_latch[0]) else $error("Latched alarm not cleared");
   reset_ones_a : assert property (@(posedge clk)
      !$past(arst_n) && arst_n |-> rx_pass == '0 && tx_pass == '0 && trib_rx_data_out == '1)
      else $error("Reset did not force all-ones");
endmodule : tal_top

// *** dv/tal_trib_model.sv ***
// Far-end tributary model: free-running port bit clocks with held data levels
`timescale 1ns/10ps
module tal_trib_model (
   // Levels chosen by the bench
   input  wire logic [27:0] rx_level,
   input  wire logic [27:0] tx_level,
   // Port side
   output logic      [27:0] bit_clock,
   output logic      [27:0] rx_data,
   output logic      [27:0] tx_data
);
   // ==========================================================
   // Clock and data
   // Offset start keeps port edges unrelated to clk
   initial begin
      bit_clock = 28'h0000000;
      rx_data   = 28'hfffffff;
      tx_data   = 28'hfffffff;
      #3;
      forever #80 bit_clock = ~bit_clock;
   end
   // Data moves on the falling edge so each rising edge sees it settled
   always @(negedge bit_clock[0]) begin
      rx_data <= rx_level;
      tx_data <= tx_level;
   end
endmodule : tal_trib_model

// *** dv/tal_top_bench.sv ***
// Self-checking bench for the tributary alarm and loopback block
`timescale 1ns/10ps
module tal_top_bench;
   logic clk, arst_n, wr_en, rd_en;
   logic [7:0] addr;
   logic [15:0] wdata, rdata;
   logic [27:0] rx_lvl, tx_lvl, bclk, rxd, txd, rx_out, tx_out;
   logic [27:0] rx_clk_out, tx_stb;
   logic [6:0]  so_clk, so_dat;
   int n_mismatch = 0;
   int total_checks = 0;
   typedef struct {logic [7:0] a; logic [15:0] w; logic [15:0] r;} tal_row_type;
   tal_row_type rows [6] = '{'{8'h40, 16'hffff, 16'hffff}, '{8'h42, 16'hffff, 16'h0fff},
      '{8'h44, 16'h1234, 16'h1234}, '{8'h46, 16'hffff, 16'h0fff}, '{8'h60, 16'hffff, 16'h0000},
      '{8'h50, 16'h0001, 16'h0001}};
   tal_trib_model u_model (.rx_level(rx_lvl), .tx_level(tx_lvl), .bit_clock(bclk), .rx_data(rxd), .tx_data(txd));
   tal_top u_dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
      .rdata(rdata), .mux_rx_clock(bclk), .mux_rx_data(rxd), .trib_rx_clock_out(rx_clk_out),
      .trib_rx_data_out(rx_out), .trib_tx_clock_in(bclk), .trib_tx_data_in(txd), .mux_tx_data(tx_out),
      .mux_tx_strobe(tx_stb), .so_clock_in(so_clk), .so_data_in(so_dat));
   // ==========================================================
   // Bus and compare tasks
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk) begin addr <= a; wdata <= d; wr_en <= 1'b1; end
      @(posedge clk) wr_en <= 1'b0;
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk) begin addr <= a; rd_en <= 1'b1; end
      @(posedge clk) rd_en <= 1'b0;
      #1;
      total_checks++;
      if (rdata !== e) begin n_mismatch++; $display("MISMATCH t=%0t got=%h exp=%h", $time, rdata, e); end
   endtask : rd_chk
   // Several port bit periods so every port has taken fresh bits
   task automatic port_chk(input logic [27:0] got_sel, input logic [27:0] e);
      logic [27:0] got;
      repeat (200) @(posedge clk);
      #1;
      got = got_sel ? tx_out : rx_out;
      total_checks++;
      if (got !== e) begin n_mismatch++; $display("MISMATCH t=%0t got=%h exp=%h", $time, got, e); end
   endtask : port_chk
   // Port 1 receive clock rises, or port 1 strobes, over exactly ten port bit periods
   task automatic cnt_chk(input int sel, input int e);
      int n;
      logic prev;
      n = 0;
      @(posedge clk);
      #1;
      prev = rx_clk_out[0];
      repeat (320) begin
         @(posedge clk);
         #1;
         if (sel ? tx_stb[0] : rx_clk_out[0] && !prev) n++;
         prev = rx_clk_out[0];
      end
      total_checks++;
      if (n !== e) begin n_mismatch++; $display("MISMATCH t=%0t got=%h exp=%h", $time, n, e); end
   endtask : cnt_chk
   task automatic print_verdict;
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   // ==========================================================
   // Clock, reset and watchdog
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      repeat (100000) @(posedge clk);
      n_mismatch++;
      print_verdict();
   end
   initial begin
      arst_n = 1'b0; wr_en = 1'b0; rd_en = 1'b0; addr = 8'h00; wdata = 16'h0000;
      rx_lvl = 28'h0000000; tx_lvl = 28'h0000000;
      so_clk = 7'h00;
      so_dat = 7'h7f;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 4; i++) rd_chk(8'h40 + 8'(2 * i), 16'h0000);
      rd_chk(8'h50, 16'h0000);
      port_chk(0, 28'hfffffff);
      port_chk(1, 28'hfffffff);
      $display("test reset done");
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd_chk(rows[i].a, rows[i].r);
      end
      $display("test registers done");
      wr(8'h50, 16'h0000);
      wr(8'h44, 16'hffff);
      port_chk(0, 28'h0000000);
      port_chk(1, 28'h0000000);
      wr(8'h40, 16'h0001);
      wr(8'h42, 16'h0800);
      port_chk(0, 28'h7fffffe);
      wr(8'h40, 16'hffff);
      wr(8'h42, 16'h0fff);
      wr(8'h48, 16'h0001);
      port_chk(0, 28'hfff0000);
      wr(8'h48, 16'h0002);
      port_chk(0, 28'h8888888);
      port_chk(1, 28'hfe88888);
      $display("test modes done");
      for (int i = 0; i < 4; i++) wr(8'h40 + 8'(2 * i), 16'h0000);
      wr(8'h48, 16'h0004);
      port_chk(0, 28'h0000000);
      port_chk(1, 28'h0000000);
      wr(8'h48, 16'h0000);
      port_chk(1, 28'hfffffff);
      $display("test disable done");
      for (int i = 0; i < 4; i++) wr(8'h40 + 8'(2 * i), 16'hffff);
      tx_lvl = 28'hfffffff;
      wr(8'h50, 16'h0005);
      port_chk(1, 28'hffffffa);
      tx_lvl = 28'haaaaaaa;
      wr(8'h50, 16'h0000);
      wr(8'h54, 16'h000b);
      wr(8'h56, 16'h0800);
      port_chk(0, 28'h800000a);
      wr(8'h48, 16'h0008);
      port_chk(0, 28'h800000a);
      cnt_chk(0, 10);
      cnt_chk(1, 10);
      $display("test loopbacks done");
      // All-ones stream: no zeros, no alignment word, remote bit held high
      wr(8'h48, 16'h0001);
      repeat (6000) @(posedge clk) so_clk <= ~so_clk;
      rd_chk(8'h34, 16'h0f0f);
      rd_chk(8'h36, 16'h000f);
      wr(8'h48, 16'h0000);
      rd_chk(8'h34, 16'h0f0f);
      rd_chk(8'h34, 16'h0000);
      $display("test framers done");
      print_verdict();
   end
endmodule : tal_top_bench
